// file: design/edge_count_pkg.sv
// shared constants and carrier types for the edge-count voltage select block
`default_nettype none
package edge_count_pkg;
    // clock rate in kHz (250 MHz)
    localparam int CLK_KHZ = 250000;
    // code width for the 16 reference steps
    localparam int CODE_W = 4;
    localparam logic [3:0] CODE_DEFAULT = 4'h0;
    // reference levels in millivolts
    localparam int HIGH_REF_MV = 1200;
    localparam int LOW_REF_BASE_MV = 600;
    localparam int LOW_REF_STEP_MV = 40;
    localparam int REF_MV_W = 11;
    // default hold times in microseconds
    localparam int LATCH_HOLD_US = 500;
    localparam int SHUTDOWN_LOW_US = 500;
    // cycle counts derived from the times above (least times: round up)
    localparam int LATCH_HOLD_CYC = (LATCH_HOLD_US * CLK_KHZ + 999) / 1000;
    localparam int SHUTDOWN_LOW_CYC =
        (SHUTDOWN_LOW_US * CLK_KHZ + 999) / 1000;
    localparam int CNT_W = 24;

    typedef enum logic [2:0] {
        ST_OFF = 3'h1,
        ST_IDLE = 3'h2,
        ST_COUNT = 3'h4
    } link_state_e;

    // reference selection presented to the analog side
    typedef struct packed {
        logic highRefEn;
        logic lowRefEn;
        logic [REF_MV_W-1:0] refMv;
    } ref_sel_s;

    // whole state of the block
    typedef struct packed {
        link_state_e st;
        logic [1:0] linkSync;
        logic [1:0] selSync;
        logic linkPrev;
        logic [CODE_W-1:0] edgeCnt;
        logic cntOver;
        logic [CODE_W-1:0] code;
        logic [CNT_W-1:0] timer;
        ref_sel_s ref_;
    } state_s;
endpackage
`default_nettype wire

// file: design/edge_count_voltage_select.sv
// edge-count single-wire reference selector
`default_nettype none
module edge_count_voltage_select #(
    parameter int LATCH_HOLD_CYC = edge_count_pkg::LATCH_HOLD_CYC,
    parameter int SHUTDOWN_LOW_CYC = edge_count_pkg::SHUTDOWN_LOW_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // pins
    input wire logic edgeCountLink,
    input wire logic refSelect,
    // reference selection and status
    output edge_count_pkg::ref_sel_s refSel,
    output logic deviceEnabled,
    output logic [3:0] latchedCode
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    edge_count_pkg::state_s s_q, s_d;
    logic linkIn, selIn, riseSeen;
    // hold limits taken from the parameters
    localparam logic [23:0] LATCH_LIM = 24'(LATCH_HOLD_CYC - 1);
    localparam logic [23:0] OFF_LIM = 24'(SHUTDOWN_LOW_CYC - 1);

    function automatic logic [10:0] low_ref_mv(input logic [3:0] c);
        low_ref_mv = 11'(edge_count_pkg::LOW_REF_BASE_MV
            + edge_count_pkg::LOW_REF_STEP_MV * int'(c));
    endfunction

    assign linkIn = s_q.linkSync[1];
    assign selIn = s_q.selSync[1];
    // one 4 ns sample per edge is far finer than 1 MHz signalling
    // edge detect
    assign riseSeen = linkIn && !s_q.linkPrev;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.linkSync = {s_q.linkSync[0], edgeCountLink};
        s_d.selSync = {s_q.selSync[0], refSelect};
        s_d.linkPrev = linkIn;
        if (linkIn != s_q.linkPrev) begin
            s_d.timer = '0;
        end else if (s_q.timer != 24'hffffff) begin
            s_d.timer = s_q.timer + 24'h1;
        end
        case (s_q.st)
            edge_count_pkg::ST_OFF: begin
                if (riseSeen) begin
                    // first edge after enable arms count 1
                    s_d.st = edge_count_pkg::ST_COUNT;
                    s_d.edgeCnt = 4'h0;
                    s_d.cntOver = 1'b0;
                end
            end
            edge_count_pkg::ST_IDLE: begin
                if (riseSeen) begin
                    s_d.st = edge_count_pkg::ST_COUNT;
                    s_d.edgeCnt = 4'h0;
                    s_d.cntOver = 1'b0;
                end
            end
            edge_count_pkg::ST_COUNT: begin
                if (riseSeen) begin
                    if (s_q.edgeCnt == 4'hf) begin
                        s_d.cntOver = 1'b1;
                    end else begin
                        s_d.edgeCnt = s_q.edgeCnt + 4'h1;
                    end
                end
                // latch after steady high
                // timer holds the low time on the rise cycle: need prev high
                if (linkIn && s_q.linkPrev && s_q.timer == LATCH_LIM) begin
                    s_d.code = s_q.edgeCnt;
                    s_d.st = edge_count_pkg::ST_IDLE;
                end
            end
            default: s_d.st = edge_count_pkg::ST_OFF;
        endcase
        // long low disables
        // a fall after a long high must not read as a long low
        if (!linkIn && !s_q.linkPrev && s_q.timer == OFF_LIM) begin
            s_d.st = edge_count_pkg::ST_OFF;
            s_d.code = edge_count_pkg::CODE_DEFAULT;
        end
        s_d.ref_.highRefEn = selIn;
        s_d.ref_.lowRefEn = !selIn;
        s_d.ref_.refMv = selIn ? 11'(edge_count_pkg::HIGH_REF_MV)
                               : low_ref_mv(s_d.code);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            // power-up default
            // the link sync and linkPrev start at the idle-high wire level (select sync starts low): no false rise
            s_q <= '{st: edge_count_pkg::ST_OFF, linkSync: 2'h3,
                     selSync: 2'h0, linkPrev: 1'b1, edgeCnt: 4'h0,
                     cntOver: 1'b0, code: edge_count_pkg::CODE_DEFAULT,
                     timer: 24'h0,
                     ref_: '{highRefEn: 1'b0, lowRefEn: 1'b1,
                             refMv: 11'(edge_count_pkg::LOW_REF_BASE_MV)}};
        end else begin
            s_q <= s_d;
        end
    end

    assign refSel = s_q.ref_;
    assign deviceEnabled = (s_q.st != edge_count_pkg::ST_OFF);
    assign latchedCode = s_q.code;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // all checks watch registered state, one cycle after the cause
    a_high_path: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.selSync[1] |=> refSel.highRefEn && !refSel.lowRefEn
            && refSel.refMv == 11'd1200)
        else $error("high reference not selected");
    a_low_path: assert property (
        @(posedge core_clk) disable iff (rst)
        !s_q.selSync[1] |=> !refSel.highRefEn && refSel.lowRefEn
            && refSel.refMv == 11'd600 + 11'd40 * 11'(s_q.code))
        else $error("low reference value wrong");
    a_first_edge: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.st != edge_count_pkg::ST_COUNT && riseSeen
        |=> s_q.st == edge_count_pkg::ST_COUNT && s_q.edgeCnt == 4'h0)
        else $error("first edge not counted as one");
    a_edge_count: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.st == edge_count_pkg::ST_COUNT && riseSeen
            && s_q.edgeCnt != 4'hf
        |=> s_q.edgeCnt == $past(s_q.edgeCnt) + 4'h1)
        else $error("edge not counted");
    a_count_saturate: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.st == edge_count_pkg::ST_COUNT && riseSeen
            && s_q.edgeCnt == 4'hf
        |=> s_q.edgeCnt == 4'hf && s_q.cntOver)
        else $error("count did not saturate");
    a_latch_value: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.st == edge_count_pkg::ST_COUNT && linkIn && s_q.linkPrev
            && s_q.timer == LATCH_LIM
        |=> latchedCode == $past(s_q.edgeCnt)
            && s_q.st == edge_count_pkg::ST_IDLE)
        else $error("count not latched after hold");
    a_latch_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.code != $past(s_q.code) && s_q.st != edge_count_pkg::ST_OFF
        |-> $past(linkIn) && $past(s_q.linkPrev)
            && $past(s_q.timer) == LATCH_LIM)
        else $error("code changed without latch hold");
    a_shutdown: assert property (
        @(posedge core_clk) disable iff (rst)
        !linkIn && !s_q.linkPrev && s_q.timer == OFF_LIM
        |=> s_q.st == edge_count_pkg::ST_OFF && s_q.code == 4'h0)
        else $error("no shutdown after long low");
    a_no_early_off: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(deviceEnabled) |-> $past(s_q.timer) == OFF_LIM)
        else $error("disabled too early");
    a_enable_on_edge: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(deviceEnabled) |-> $past(riseSeen))
        else $error("enabled without a rising edge");
    a_default_ref: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(deviceEnabled) && refSel.lowRefEn
        |-> refSel.refMv == 11'd600)
        else $error("low reference not back to default");
    a_reset_values: assert property (
        @(posedge core_clk)
        rst |=> !deviceEnabled && latchedCode == 4'h0 && refSel.lowRefEn
            && refSel.refMv == 11'd600)
        else $error("reset defaults wrong");
    a_sel_toggle: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(s_q.selSync[1]) |=> $rose(refSel.highRefEn))
        else $error("select toggle not followed");
    a_timer_param: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(linkIn) |=> s_q.timer == 24'h0)
        else $error("timer not restarted on edge");

    // main scenarios: program, shutdown, top code, saturation, select
    c_program: cover property (@(posedge core_clk) disable iff (rst)
        s_q.st == edge_count_pkg::ST_COUNT
            ##1 s_q.st == edge_count_pkg::ST_IDLE);
    c_shutdown: cover property (@(posedge core_clk) disable iff (rst)
        $fell(deviceEnabled));
    c_top_code: cover property (@(posedge core_clk) disable iff (rst)
        s_q.code == 4'hf);
    c_saturate: cover property (@(posedge core_clk) disable iff (rst)
        $rose(s_q.cntOver));
    c_high_sel: cover property (@(posedge core_clk) disable iff (rst)
        $rose(refSel.highRefEn));
endmodule // edge_count_voltage_select
`default_nettype wire

// file: tb/host_link_model.sv
// host-side driver of the edge-count programming wire
`default_nettype none
module host_link_model (
    // clock
    input wire logic core_clk,
    // programming wire, idle high; a rising edge enables and a long low disables
    output logic edgeCountLink
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // wire bursts
    // ----------------------------------------
    initial edgeCountLink = 1'b1;
    // ten cycles a pulse (25 MHz at the 4 ns clock), far above the 1 MHz ceiling
    // the wire is left high after a burst so the code latches
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk) edgeCountLink <= 1'b0;
            repeat (5) @(posedge core_clk);
            edgeCountLink <= 1'b1;
            repeat (4) @(posedge core_clk);
        end
    endtask
    // low past the shutdown count; stays low until wake is called
    task automatic shut();
        @(posedge core_clk) edgeCountLink <= 1'b0;
        repeat (50) @(posedge core_clk);
    endtask
    task automatic wake();
        @(posedge core_clk) edgeCountLink <= 1'b1;
    endtask
endmodule // host_link_model
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the edge-count reference selector
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    err_count++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // short counts keep the run brief
    localparam int LATCH = 20;
    localparam int SHUT = 40;
    localparam edge_count_pkg::ref_sel_s HIGH = '{1'b1, 1'b0, 11'h4b0};
    typedef struct {int n; logic [3:0] code; logic [10:0] mv;} row_s;
    logic core_clk, rst, refSelect, deviceEnabled, edgeCountLink;
    logic [3:0] latchedCode;
    edge_count_pkg::ref_sel_s refSel;
    int err_count = 0;
    int tests_run = 0;
    // edges sent, code and millivolts expected; 17 edges saturate
    row_s rows[5] = '{'{1, 4'h0, 11'h258}, '{2, 4'h1, 11'h280},
        '{8, 4'h7, 11'h370}, '{16, 4'hf, 11'h4b0}, '{17, 4'hf, 11'h4b0}};
    host_link_model host_link_model_i (.core_clk(core_clk),
        .edgeCountLink(edgeCountLink));
    edge_count_voltage_select #(.LATCH_HOLD_CYC(LATCH),
        .SHUTDOWN_LOW_CYC(SHUT)) edge_count_voltage_select_i (
        .core_clk(core_clk), .rst(rst), .edgeCountLink(edgeCountLink),
        .refSelect(refSelect), .refSel(refSel),
        .deviceEnabled(deviceEnabled), .latchedCode(latchedCode));
    function automatic edge_count_pkg::ref_sel_s lowRef(logic [10:0] mv);
        return '{1'b0, 1'b1, mv};
    endfunction
    // #1 lets the edge's own updates land before sampling
    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        refSelect = 1'b0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        waitc(2);
        foreach (rows[i]) begin
            host_link_model_i.send(rows[i].n);
            waitc(LATCH + 6);
            `CHK("code", rows[i].code, latchedCode)
            `CHK("ref", lowRef(rows[i].mv), refSel)
            `CHK("enabled", 1'b1, deviceEnabled)
        end
        $display("test table done");
        host_link_model_i.send(3);
        waitc(8);
        `CHK("early code", 4'hf, latchedCode)
        waitc(LATCH);
        `CHK("latched code", 4'h2, latchedCode)
        $display("test latch done");
        @(posedge core_clk) refSelect <= 1'b1;
        waitc(4);
        `CHK("high ref", HIGH, refSel)
        @(posedge core_clk) refSelect <= 1'b0;
        waitc(4);
        `CHK("low ref", lowRef(11'h2a8), refSel)
        $display("test select done");
        host_link_model_i.shut();
        waitc(1);
        `CHK("off", 1'b0, deviceEnabled)
        `CHK("off code", 4'h0, latchedCode)
        `CHK("off ref", lowRef(11'h258), refSel)
        host_link_model_i.wake();
        waitc(LATCH + 8);
        `CHK("woken", 1'b1, deviceEnabled)
        `CHK("woken ref", lowRef(11'h258), refSel)
        $display("test shutdown done");
        host_link_model_i.send(5);
        waitc(LATCH + 6);
        `CHK("pre reset code", 4'h4, latchedCode)
        `CHK("pre reset ref", lowRef(11'h2f8), refSel)
        @(posedge core_clk) rst <= 1'b1;
        waitc(3);
        @(posedge core_clk) rst <= 1'b0;
        waitc(2);
        `CHK("reset ref", lowRef(11'h258), refSel)
        `CHK("reset code", 4'h0, latchedCode)
        `CHK("reset off", 1'b0, deviceEnabled)
        $display("test reset done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
